/* rtl/tws_serial_io.sv */
// three-wire serial port: APB registers, clock divider, 8-bit shifter
// assumes pins are combined outside from the output enables
//
// Contract
// - control register 8 bits, resets to zero
// - bit 7 enables port, else stopped
// - rate bits pick divide by 4/8/16/32
// - bit 2 picks MSB or LSB first
// - bit 1 picks external or internal clock
// - each transfer moves exactly eight bits
// - falling edge shifts, drives data-out latch
// - rising edge samples data-in pin
// - after eighth bit stop and interrupt
// - write starts only when enabled and idle
// - write while disabled never gets sent
// - external clock: later writes change nothing
// - stopped mode releases all three pins
// - data-out push-pull while running
// - 8-bit shifter, no reset value
`timescale 1ns/1ps
`default_nettype none
module tws_serial_io (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [tws_pkg::ADDR_W-1:0] paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      sck_i,
    output logic                           sck_o,
    output logic                           sck_oe,
    output logic                           so_o,
    output logic                           so_oe,
    input  wire logic                      si_i,
    output logic                           irq
);
    import tws_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic [4:0] div_cnt;
    logic       busy;
    logic       sck_prev;
    logic       stat_done;
    logic       mask_done;
    // checker helpers, counted apart from the shifter's own counter
    logic [3:0] fall_seen;
    logic [4:0] low_run;

    // half period of the internal clock in pclk cycles
    function automatic logic [4:0] half_of(input logic [1:0] code);
        half_of = DIV_MIN << code;
    endfunction

    // apb decode; one wait state so every answer comes from a flop
    wire        next_pready = psel & penable & ~pready;
    wire        commit      = psel & penable & pready;
    wire        hit_ctrl    = paddr == ADDR_CTRL;
    wire        hit_data    = paddr == ADDR_DATA;
    wire        hit_stat    = paddr == ADDR_STAT;
    wire        hit_mask    = paddr == ADDR_MASK;
    wire        mapped      = hit_ctrl | hit_data | hit_stat | hit_mask;
    wire        wr_ctrl     = commit & pwrite & hit_ctrl;
    wire        wr_data     = commit & pwrite & hit_data;
    wire        wr_stat     = commit & pwrite & hit_stat;
    wire        wr_mask     = commit & pwrite & hit_mask;

    // control fields
    wire        en          = ctrl[EN_BIT];
    wire        src_int     = ctrl[SRC_BIT];
    wire        lsb         = ctrl[ORDER_BIT];
    wire [1:0]  rate        = ctrl[RATE_HI:RATE_LO];
    wire [4:0]  half_m1     = half_of(rate) - 5'h01;

    // serial clock edges seen by the shifter
    wire        sck_lvl     = src_int ? sck_o : sck_i;
    wire        fall_ev     = busy & sck_prev & ~sck_lvl;
    wire        rise_ev     = busy & ~sck_prev & sck_lvl;
    wire        done_ev     = rise_ev & (bitcnt == LAST_BIT);
    // a start needs enable and an idle, high clock line
    wire        start       = wr_data & en & ~busy & (src_int | sck_i);
    wire        out_bit     = lsb ? sh[0] : sh[7];
    wire        next_done   = (stat_done & ~(wr_stat & pwdata[DONE_BIT])) | done_ev;

    // read mux; unused bits read zero
    wire [7:0]  stat_rd     = {6'h00, busy, stat_done};
    wire [7:0]  rd_val      = hit_ctrl ? ctrl :
                              hit_data ? sh :
                              hit_stat ? stat_rd :
                              hit_mask ? {7'h00, mask_done} : 8'h00;

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pready & ~mapped;
            if (next_pready && !pwrite)
                prdata <= {24'h00_0000, rd_val};
        end
    end

    // mode register; reserved bits kept at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= pwdata[7:0] & CTRL_WMASK;
    end

    // busy flag and bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy   <= 1'b0;
            bitcnt <= 4'h0;
        end else if (!en) begin
            busy   <= 1'b0;
            bitcnt <= 4'h0;
        end else if (start) begin
            busy   <= 1'b1;
            bitcnt <= 4'h0;
        end else if (done_ev) begin
            busy   <= 1'b0;
            bitcnt <= 4'h0;
        end else if (rise_ev) begin
            bitcnt <= bitcnt + 4'h1;
        end
    end

    // internal clock divider; idles high so the first edge is a fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_o   <= 1'b1;
            div_cnt <= 5'h00;
        end else if (!busy || !src_int) begin
            sck_o   <= 1'b1;
            div_cnt <= 5'h00;
        end else if (div_cnt == half_m1) begin
            sck_o   <= ~sck_o;
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // edge detector history; pins are synchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sck_prev <= 1'b1;
        else
            sck_prev <= sck_lvl;
    end

    // shift register; no reset, content is undefined until written
    // writes during a transfer are dropped rather than corrupt it
    always_ff @(posedge pclk) begin
        if (wr_data && !busy)
            sh <= pwdata[7:0];
        else if (fall_ev)
            sh <= lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
        else if (rise_ev && lsb)
            sh[7] <= si_i;
        else if (rise_ev)
            sh[0] <= si_i;
    end

    // data-out latch and pin drive; stopped mode releases the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_o   <= 1'b0;
            so_oe  <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            if (fall_ev)
                so_o <= out_bit;
            so_oe  <= en;
            sck_oe <= en & src_int;
        end
    end

    // sticky done flag, set beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_done <= 1'b0;
            mask_done <= 1'b0;
            irq       <= 1'b0;
        end else begin
            stat_done <= next_done;
            if (wr_mask)
                mask_done <= pwdata[DONE_BIT];
            irq <= next_done & (wr_mask ? pwdata[DONE_BIT] : mask_done);
        end
    end

    // falls seen since the last start; an independent witness of the word length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fall_seen <= 4'h0;
        else if (start)
            fall_seen <= 4'h0;
        else if (fall_ev)
            fall_seen <= fall_seen + 4'h1;
    end

    // length of the current low phase of the internal clock
    // counted in pclk cycles so every rate can be checked, not only the fastest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_run <= 5'h00;
        else if (sck_o)
            low_run <= 5'h00;
        else
            low_run <= low_run + 5'h01;
    end

    // checks on the shifter and pins
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    ctrl_reset_a: assert property ($rose(presetn) |-> ctrl == 8'h00)
        else $error("control not zero after reset");
    stop_idle_a: assert property (!en |=> !busy)
        else $error("busy while stopped");
    rate_fast_a: assert property (busy && src_int && rate == 2'h0 && $fell(sck_o)
        |=> !sck_o ##1 sck_o)
        else $error("divide by 4 clock wrong");
    lsb_out_a: assert property (fall_ev && lsb |=> so_o == $past(sh[0]))
        else $error("lsb first bit wrong");
    msb_out_a: assert property (fall_ev && !lsb |=> so_o == $past(sh[7]))
        else $error("msb first bit wrong");
    clk_drive_a: assert property (en && !src_int |=> !sck_oe)
        else $error("clock pin driven in external mode");
    eight_bits_a: assert property (done_ev |-> fall_seen == 4'h8)
        else $error("transfer not eight bits");
    sample_rise_a: assert property (rise_ev && !lsb |=> sh[0] == $past(si_i))
        else $error("input not sampled on rise");
    done_irq_a: assert property (done_ev |=> stat_done && !busy)
        else $error("no stop or flag after eighth bit");
    start_cond_a: assert property ($rose(busy) |-> $past(en) && ($past(src_int)
        || $past(sck_i)))
        else $error("start without conditions");
    off_write_a: assert property (wr_data && !en |=> !busy)
        else $error("disabled write started");
    ext_hold_a: assert property (busy && !src_int && wr_data && !fall_ev
        && !rise_ev |=> sh == $past(sh))
        else $error("write changed shifter mid transfer");
    stop_pins_a: assert property (!en |=> !so_oe && !sck_oe)
        else $error("pins held in stopped mode");
    idle_high_a: assert property (!busy && src_int |=> sck_o)
        else $error("internal clock not idle high");

    // rate, interrupt level and pin hold
    rate_half_a: assert property (busy && src_int && $rose(sck_o)
        |-> low_run == (5'h02 << rate))
        else $error("low phase length wrong for rate");
    irq_level_a: assert property (irq == (stat_done && mask_done))
        else $error("interrupt level not status and mask");
    so_hold_a: assert property (!fall_ev |=> $stable(so_o))
        else $error("data out moved without a fall");
    lsb_in_a: assert property (rise_ev && lsb |=> sh[7] == $past(si_i))
        else $error("lsb first input bit wrong");
    start_busy_a: assert property (start |=> busy)
        else $error("legal start did not begin transfer");
    run_drive_a: assert property (busy |-> so_oe)
        else $error("data out not driven while running");

    // bus answer shape
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");

    int_xfer_c: cover property (done_ev && src_int);
    ext_xfer_c: cover property (done_ev && !src_int);
    irq_rise_c: cover property ($rose(irq));
    lsb_xfer_c: cover property (done_ev && lsb);
    drop_write_c: cover property (wr_data && busy);
endmodule // tws_serial_io
`default_nettype wire

/* common/tws_pkg.sv */
// constants for the three-wire serial port block
// assumes a 32-bit APB slave port and a 25 MHz pclk
package tws_pkg;
    localparam int          ADDR_W     = 18;
    localparam int          CLK_KHZ    = 25000;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL   = 16'hFF72;
    localparam logic [15:0] IDX_DATA   = 16'hFF73;
    localparam logic [15:0] IDX_STAT   = 16'hFF74;
    localparam logic [15:0] IDX_MASK   = 16'hFF75;
    localparam logic [17:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
    localparam logic [17:0] ADDR_DATA  = {IDX_DATA, 2'b00};
    localparam logic [17:0] ADDR_STAT  = {IDX_STAT, 2'b00};
    localparam logic [17:0] ADDR_MASK  = {IDX_MASK, 2'b00};
    // serial_mode_control fields
    localparam int          EN_BIT     = 7;
    localparam int          RATE_HI    = 5;
    localparam int          RATE_LO    = 4;
    localparam int          ORDER_BIT  = 2;
    localparam int          SRC_BIT    = 1;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  CTRL_WMASK = 8'hB6;
    // status fields
    localparam int          DONE_BIT   = 0;
    localparam int          BUSY_BIT   = 1;
    localparam logic [3:0]  LAST_BIT   = 4'h7;
    localparam logic [4:0]  DIV_MIN    = 5'h02;
endpackage

/* test/tws_peer.sv */
// far-side model: peripheral on the three-wire link, can also make the clock
// assumes sck is the resolved clock line and changes only after pclk edges
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
    input  wire logic       pclk,
    input  wire logic       sck,
    input  wire logic       so,
    input  wire logic [7:0] tx,
    input  wire logic       ext,
    input  wire logic       start,
    output logic            si,
    output logic            ext_sck,
    output logic [7:0]      rx,
    output logic [4:0]      low_len
);
    logic       sck_d   = 1'b1;
    logic [3:0] nbit    = 4'h0;
    logic [4:0] cnt     = 5'h00;
    logic [4:0] phases  = 5'h00;
    logic [2:0] div     = 3'h0;
    initial si = 1'b0;
    initial ext_sck = 1'b1;
    // one clock burst of 16 phases, half period 8 pclk, idle high
    always @(posedge pclk) begin
        if (start) begin
            phases <= ext ? 5'h10 : 5'h00;
            div <= 3'h0;
        end else if (phases != 5'h00) begin
            div <= div + 3'h1;
            if (div == 3'h7) begin
                ext_sck <= !ext_sck;
                phases <= phases - 5'h01;
            end
        end
    end
    // data moves on fall so it is steady across rise; stale bit toggles
    always @(posedge pclk) begin
        sck_d <= sck;
        cnt <= sck ? 5'h00 : cnt + 5'h01;
        if (start) begin
            nbit <= 4'h0;
        end else if (sck_d && !sck) begin
            si <= tx[3'h7 - nbit[2:0]];
        end else if (!sck_d && sck) begin
            nbit <= nbit + 4'h1;
            rx <= {rx[6:0], so};
            low_len <= cnt;
        end else if (sck && nbit == 4'h8) begin
            si <= !si;
        end
    end
endmodule // tws_peer
`default_nettype wire

/* test/three_wire_serial_io_bench.sv */
// bench: APB tasks drive the port, a peer model answers on the link
// assumes the design package and the peer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_io_bench;
    import tws_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic        pready, pslverr, slv, sck_o, sck_oe, so_o, so_oe, si, irq, ext_sck;
    logic        ext = 1'b0, start = 1'b0;
    logic [7:0]  tx = 8'h00, rx;
    logic [4:0]  low_len;
    wire         line = sck_oe ? sck_o : ext_sck;
    int          err_count = 0, samples_checked = 0;
    always #20 pclk = !pclk;
    tws_serial_io uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_i(line), .sck_o(sck_o), .sck_oe(sck_oe),
        .so_o(so_o), .so_oe(so_oe), .si_i(si), .irq(irq));
    tws_peer peer (.pclk(pclk), .sck(line), .so(so_o), .tx(tx), .ext(ext), .start(start),
        .si(si), .ext_sck(ext_sck), .rx(rx), .low_len(low_len));
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // one APB access; the wait on pready is bounded
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1'b1, "no pready");
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction
    // full transfer: peer sends p while the port sends d
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] p);
        int n;
        n = 0;
        tx <= p;
        ext <= !c[SRC_BIT];
        apb(1'b1, ADDR_CTRL, c);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b1, ADDR_DATA, d);
        if (!c[SRC_BIT]) apb(1'b1, ADDR_DATA, ~d);
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        check(irq, 1'b1, "no irq");
        check(rx, c[ORDER_BIT] ? rev(d) : d, "sent byte");
        if (c[SRC_BIT]) check(low_len, 5'h02 << c[5:4], "half period");
        apb(1'b0, ADDR_DATA, 8'h00);
        check(rdv, {24'h0, c[ORDER_BIT] ? rev(p) : p}, "received");
        apb(1'b0, ADDR_STAT, 8'h00);
        check(rdv, 32'h1, "status");
        apb(1'b1, ADDR_STAT, 8'h01);
        @(posedge pclk);
        check(irq, 1'b0, "irq clear");
    endtask
    initial begin
        #800000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 8'h00);
        check(rdv, 32'h0, "ctrl reset");
        check({sck_oe, so_oe, line}, 3'b001, "stopped pins");
        apb(1'b0, ADDR_MASK + 18'h4, 8'h00);
        check(slv, 1'b1, "unmapped");
        apb(1'b1, ADDR_MASK, 8'h01);
        apb(1'b1, ADDR_DATA, 8'h5A);
        apb(1'b1, ADDR_CTRL, 8'h82);
        repeat (60) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 8'h00);
        check({rdv, irq}, 33'h0, "disabled write");
        apb(1'b1, ADDR_CTRL, 8'hB6);
        apb(1'b0, ADDR_CTRL, 8'h00);
        check(rdv, 32'hB6, "ctrl bits");
        check({sck_oe, so_oe}, 2'b11, "enabled pins");
        for (int r = 0; r < 4; r++) begin
            for (int o = 0; o < 2; o++) begin
                xfer(8'h82 | 8'(r << 4) | 8'(o << 2), 8'hA1 + 8'(r * 37 + o), 8'h4E ^ 8'(r + o));
            end
        end
        xfer(8'h80, 8'h3C, 8'h96);
        xfer(8'h84, 8'hC3, 8'h69);
        conclude();
    end
endmodule // three_wire_serial_io_bench
`default_nettype wire
